// [inc/ptc_regs.svh]
// Register indices, field positions and reset values of the timer core.
//
// Contract
// (RULE1) Transfer controller service clears flag A.
// (RULE2) Flag A clears by read-one, write-zero.
// (RULE3) Compare match on register A sets flag A.
// (RULE4) Capture into register A sets flag A.
// (RULE5) Three 16-bit counters, reset to zero.
// (RULE6) Channel 0 counts up; 1, 2 phase-direction.
// (RULE7) Counters and general registers: word access only.
// (RULE8) Eight general registers: four, two, two.
// (RULE9) General registers reset to all ones.
// (RULE10) Channel 0 C/D buffer A/B.
// (RULE11) Run bits 2..0 stop or start counters.
// (RULE12) Run register resets zero; reserved written zero.
// (RULE13) Software stops counter before mode changes.
// (RULE14) Run cleared: counter stops, pin level kept.
// (RULE15) I/O control write while stopped loads initial level.
// (RULE16) Sync bit joins channel to preset/clear.
// (RULE17) Synchronous operation needs two sync bits set.
// (RULE18) Sync clear also needs a clear source.
// (RULE19) Sync register resets zero; reserved written zero.
// (RULE20) Halt bit 13 stops the unit.
// (RULE21) Halt register resets to 0x3FFF.
// (RULE22) Byte registers take byte and word access.
// (RULE23) Counter wrap from all ones sets overflow.
// (RULE24) Byte writes to word registers are ignored.
// (RULE25) Synchronised counters are preset together.
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

// ****************************************************************
// Word indices on the internal bus
// ****************************************************************
`define PTC_IDX_CNT0 4'h0
`define PTC_IDX_CNT2 4'h2
`define PTC_IDX_GR0 4'h3
`define PTC_IDX_GR7 4'hA
`define PTC_IDX_RUNSYNC 4'hB
`define PTC_IDX_STAT0 4'hC
`define PTC_IDX_STAT2 4'hE
`define PTC_IDX_HALT 4'hF

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PTC_CH_BITS 2:0
`define PTC_RUN_BITS 10:8
`define PTC_STAT_FLAG_A 0
`define PTC_STAT_OVF 4
`define PTC_HALT_BIT 13
`define PTC_CNT_RESET 16'h0000
`define PTC_GR_RESET 16'hFFFF
`define PTC_CNT_MAX 16'hFFFF
`define PTC_HALT_RESET 16'h3FFF
`define PTC_BYTE_RESET 3'h0
`define PTC_BE_WORD 2'h3

`endif

// [inc/ptc_pkg.sv]
// Types shared by the timer core and its bench.
package ptc_pkg;

  // One access on the internal 16-bit bus.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [3:0] addr;
    logic [15:0] wdata;
  } ptc_bus_req_type;

  // Transfer controller service of one channel's match-A request.
  typedef struct packed {
    logic ack;
    logic disable_select_bit;
    logic cnt_zero;
  } ptc_xfer_type;

endpackage : ptc_pkg

// [src/ptc_core.sv]
// Three-channel 16-bit timer core with its bus-visible registers.
`include "ptc_regs.svh"

module ptc_core
  import ptc_pkg::*;
#(
  parameter int NCH = 3,
  parameter int NGR = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  // Internal bus
  input wire ptc_bus_req_type bus_req,
  output logic [15:0] bus_rdata_r,
  output logic bus_rvalid_r,
  // Count clocks and direction
  input wire logic [NCH-1:0] count_tick,
  input wire logic [NCH-1:0] phase_mode,
  input wire logic [NCH-1:0] count_down,
  // Counter clearing sources
  input wire logic [NCH-1:0] clr_on_match_a,
  input wire logic [NCH-1:0] clr_by_sync,
  // General register function and capture strobes
  input wire logic [NGR-1:0] gr_capture_mode,
  input wire logic [NGR-1:0] capture_in,
  input wire logic [1:0] buffer_en,
  // Transfer controller service
  input wire ptc_xfer_type [NCH-1:0] xfer,
  // Pin control
  input wire logic [NCH-1:0] match_level,
  input wire logic [NCH-1:0] io_ctrl_wr,
  input wire logic [NCH-1:0] init_level,
  // Status and pins
  output logic [NCH-1:0] match_capture_flag_a_r,
  output logic [NCH-1:0] overflow_flag_r,
  output logic [NCH-1:0] timer_io_pin_r,
  output logic timer_halt_bit_r
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] channel_counter_r [NCH];
  logic [15:0] channel_counter_nxt [NCH];
  logic [15:0] general_regs_r [NGR];
  logic [15:0] general_regs_nxt [NGR];
  logic [2:0] run_control_reg_r;
  logic [2:0] run_control_reg_nxt;
  logic [2:0] sync_select_reg_r;
  logic [2:0] sync_select_reg_nxt;
  logic [15:0] halt_control_reg_r;
  logic [15:0] halt_control_reg_nxt;
  logic [NCH-1:0] flag_a_nxt;
  logic [NCH-1:0] ovf_nxt;
  logic [NCH-1:0] flag_a_seen_r;
  logic [NCH-1:0] flag_a_seen_nxt;
  logic [NCH-1:0] ovf_seen_r;
  logic [NCH-1:0] ovf_seen_nxt;
  logic [NCH-1:0] pin_nxt;
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;
  logic clear_all;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Channel that owns each general register.
  function automatic int gr_chan(input int i);
    gr_chan = (i < 4) ? 0 : ((i < 6) ? 1 : 2);
  endfunction : gr_chan

  // Index of a channel's register A.
  function automatic int gr_a_of(input int c);
    gr_a_of = (c == 0) ? 0 : (2 * c + 2);
  endfunction : gr_a_of

  logic word_wr;
  logic [NCH-1:0] live;
  logic [NGR-1:0] gr_match;
  logic [NGR-1:0] gr_cap;
  logic [NCH-1:0] clr_evt;
  logic sync_clr;

  assign clear_all = ~rst_n | hw_standby;
  assign word_wr = bus_req.wr & (bus_req.be == `PTC_BE_WORD); // RULE7 RULE24

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      // A halted unit freezes and raises no events.
      live[c] = run_control_reg_r[c] & ~halt_control_reg_r[`PTC_HALT_BIT];
    end
    for (int i = 0; i < NGR; i++)
    begin
      gr_match[i] = ~gr_capture_mode[i] & ~halt_control_reg_r[`PTC_HALT_BIT]
        & (channel_counter_r[gr_chan(i)] == general_regs_r[i]);
      gr_cap[i] = gr_capture_mode[i] & capture_in[i]
        & ~halt_control_reg_r[`PTC_HALT_BIT];
    end
    sync_clr = 1'b0;
    for (int c = 0; c < NCH; c++)
    begin
      clr_evt[c] = clr_on_match_a[c] & gr_match[gr_a_of(c)] & live[c];
      if (clr_evt[c] & sync_select_reg_r[c])
      begin
        sync_clr = 1'b1; // RULE16
      end
    end
  end

  // ****************************************************************
  // Counters, general registers and flags
  // ****************************************************************
  always_comb
  begin
    logic [3:0] a;
    a = bus_req.addr;
    for (int c = 0; c < NCH; c++)
    begin
      channel_counter_nxt[c] = channel_counter_r[c];
      flag_a_nxt[c] = match_capture_flag_a_r[c];
      ovf_nxt[c] = overflow_flag_r[c];
      flag_a_seen_nxt[c] = flag_a_seen_r[c];
      ovf_seen_nxt[c] = ovf_seen_r[c];
      pin_nxt[c] = timer_io_pin_r[c];
    end
    for (int i = 0; i < NGR; i++)
    begin
      general_regs_nxt[i] = general_regs_r[i];
    end
    run_control_reg_nxt = run_control_reg_r;
    sync_select_reg_nxt = sync_select_reg_r;
    halt_control_reg_nxt = halt_control_reg_r;

    // Counting; a stopped channel holds its value except when a synchronous clear zeroes it.
    for (int c = 0; c < NCH; c++)
    begin
      if (live[c] & count_tick[c])
      begin
        if ((c != 0) & phase_mode[c] & count_down[c]) // RULE6
        begin
          channel_counter_nxt[c] = channel_counter_r[c] - 16'h0001;
        end
        else
        begin
          channel_counter_nxt[c] = channel_counter_r[c] + 16'h0001;
        end
      end
      if (clr_evt[c] | (sync_clr & sync_select_reg_r[c] & clr_by_sync[c]))
      begin
        channel_counter_nxt[c] = `PTC_CNT_RESET; // RULE16 RULE18
      end
      // Pin follows compare match A only while the channel runs.
      if (live[c] & gr_match[gr_a_of(c)])
      begin
        pin_nxt[c] = match_level[c]; // RULE14
      end
      if (io_ctrl_wr[c] & ~run_control_reg_r[c])
      begin
        pin_nxt[c] = init_level[c]; // RULE15
      end
    end

    // Capture and buffer transfers.
    for (int i = 0; i < NGR; i++)
    begin
      if (gr_cap[i])
      begin
        general_regs_nxt[i] = channel_counter_r[gr_chan(i)];
      end
    end
    for (int b = 0; b < 2; b++)
    begin
      if (buffer_en[b] & gr_cap[b])
      begin
        general_regs_nxt[b + 2] = general_regs_r[b]; // RULE10
      end
      else if (buffer_en[b] & gr_match[b])
      begin
        general_regs_nxt[b] = general_regs_r[b + 2]; // RULE10
      end
    end

    // Software writes take priority over counting in the same cycle.
    if (word_wr & (a <= `PTC_IDX_CNT2))
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if ((4'(c) == a)
          | (sync_select_reg_r[a[1:0]] & sync_select_reg_r[c]))
        begin
          channel_counter_nxt[c] = bus_req.wdata; // RULE25 RULE16
        end
      end
    end
    if (word_wr & (a >= `PTC_IDX_GR0) & (a <= `PTC_IDX_GR7))
    begin
      general_regs_nxt[3'(a - `PTC_IDX_GR0)] = bus_req.wdata; // RULE7
    end
    if (bus_req.wr & (a == `PTC_IDX_RUNSYNC))
    begin
      if (bus_req.be[1])
      begin
        run_control_reg_nxt = bus_req.wdata[`PTC_RUN_BITS]; // RULE11 RULE22
      end
      if (bus_req.be[0])
      begin
        sync_select_reg_nxt = bus_req.wdata[`PTC_CH_BITS]; // RULE22
      end
    end
    if (bus_req.wr & (a == `PTC_IDX_HALT))
    begin
      if (bus_req.be[1])
      begin
        halt_control_reg_nxt[15:8] = bus_req.wdata[15:8]; // RULE20
      end
      if (bus_req.be[0])
      begin
        halt_control_reg_nxt[7:0] = bus_req.wdata[7:0];
      end
    end

    // Flag clearing, then setting, so a same-cycle event is kept.
    for (int c = 0; c < NCH; c++)
    begin
      if (bus_req.rd & (a == `PTC_IDX_STAT0 + 4'(c)))
      begin
        flag_a_seen_nxt[c] = flag_a_seen_r[c] | match_capture_flag_a_r[c];
        ovf_seen_nxt[c] = ovf_seen_r[c] | overflow_flag_r[c];
      end
      if (bus_req.wr & bus_req.be[0] & (a == `PTC_IDX_STAT0 + 4'(c)))
      begin
        if (~bus_req.wdata[`PTC_STAT_FLAG_A] & flag_a_seen_r[c])
        begin
          flag_a_nxt[c] = 1'b0; // RULE2
          flag_a_seen_nxt[c] = 1'b0;
        end
        if (~bus_req.wdata[`PTC_STAT_OVF] & ovf_seen_r[c])
        begin
          ovf_nxt[c] = 1'b0; // RULE23
          ovf_seen_nxt[c] = 1'b0;
        end
      end
      if (xfer[c].ack & ~xfer[c].disable_select_bit & ~xfer[c].cnt_zero)
      begin
        flag_a_nxt[c] = 1'b0; // RULE1
        flag_a_seen_nxt[c] = 1'b0;
      end
      if (gr_match[gr_a_of(c)] | gr_cap[gr_a_of(c)]) // RULE3 RULE4
      begin
        flag_a_nxt[c] = 1'b1;
      end
      if (live[c] & count_tick[c] & ~((c != 0) & phase_mode[c]
        & count_down[c]) & (channel_counter_r[c] == `PTC_CNT_MAX))
      begin
        ovf_nxt[c] = 1'b1; // RULE23
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (clear_all)
    begin
      channel_counter_r <= '{default: `PTC_CNT_RESET}; // RULE5
      general_regs_r <= '{default: `PTC_GR_RESET}; // RULE8 RULE9
      run_control_reg_r <= `PTC_BYTE_RESET; // RULE12
      sync_select_reg_r <= `PTC_BYTE_RESET; // RULE19
      halt_control_reg_r <= `PTC_HALT_RESET; // RULE21
      match_capture_flag_a_r <= '0;
      overflow_flag_r <= '0;
      flag_a_seen_r <= '0;
      ovf_seen_r <= '0;
      timer_io_pin_r <= '0;
      timer_halt_bit_r <= 1'b0;
      bus_rdata_r <= 16'h0000;
      bus_rvalid_r <= 1'b0;
    end
    else
    begin
      channel_counter_r <= channel_counter_nxt;
      general_regs_r <= general_regs_nxt;
      run_control_reg_r <= run_control_reg_nxt;
      sync_select_reg_r <= sync_select_reg_nxt;
      halt_control_reg_r <= halt_control_reg_nxt;
      match_capture_flag_a_r <= flag_a_nxt;
      overflow_flag_r <= ovf_nxt;
      flag_a_seen_r <= flag_a_seen_nxt;
      ovf_seen_r <= ovf_seen_nxt;
      timer_io_pin_r <= pin_nxt;
      timer_halt_bit_r <= halt_control_reg_nxt[`PTC_HALT_BIT];
      bus_rdata_r <= rdata_nxt;
      bus_rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Data returns one cycle after the read strobe; all sixteen indices are mapped.
  always_comb
  begin
    logic [3:0] a;
    a = bus_req.addr;
    rdata_nxt = 16'h0000;
    rvalid_nxt = bus_req.rd;
    if (a <= `PTC_IDX_CNT2)
    begin
      rdata_nxt = channel_counter_r[a[1:0]];
    end
    else if (a <= `PTC_IDX_GR7)
    begin
      rdata_nxt = general_regs_r[3'(a - `PTC_IDX_GR0)];
    end
    else if (a == `PTC_IDX_RUNSYNC)
    begin
      rdata_nxt = {5'h00, run_control_reg_r, 5'h00, sync_select_reg_r};
    end
    else if (a <= `PTC_IDX_STAT2)
    begin
      rdata_nxt[`PTC_STAT_FLAG_A] =
        match_capture_flag_a_r[2'(a - `PTC_IDX_STAT0)];
      rdata_nxt[`PTC_STAT_OVF] = overflow_flag_r[2'(a - `PTC_IDX_STAT0)];
    end
    else
    begin
      rdata_nxt = halt_control_reg_r;
    end
  end

endmodule : ptc_core

// [dv/ptc_core_assertions.sv]
// Concurrent checks on the ports of the timer core.
module ptc_core_assertions
  import ptc_pkg::*;
#(
  parameter int NCH = 3,
  parameter int NGR = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  // Internal bus
  input wire ptc_bus_req_type bus_req,
  input wire logic bus_rvalid_r,
  // Events
  input wire logic [NGR-1:0] gr_capture_mode,
  input wire logic [NGR-1:0] capture_in,
  input wire ptc_xfer_type [NCH-1:0] xfer,
  input wire logic [NCH-1:0] io_ctrl_wr,
  // Status and pins
  input wire logic [NCH-1:0] match_capture_flag_a_r,
  input wire logic [NCH-1:0] overflow_flag_r,
  input wire logic [NCH-1:0] timer_io_pin_r,
  input wire logic timer_halt_bit_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || hw_standby);

  // ****************************************************************
  // Properties
  // ****************************************************************
  rd_answer_a: assert property (bus_req.rd |=> bus_rvalid_r)
    else $error("read not answered next cycle");
  rd_quiet_a: assert property (!bus_req.rd |=> !bus_rvalid_r)
    else $error("read answer without read");
  cap_sets_a: assert property (gr_capture_mode[0] && capture_in[0]
    && !timer_halt_bit_r |=> match_capture_flag_a_r[0])
    else $error("capture left flag clear");
  xfer_clear_a: assert property (match_capture_flag_a_r[1]
    && gr_capture_mode[4] && !capture_in[4] && xfer[1].ack
    && !xfer[1].disable_select_bit && !xfer[1].cnt_zero |=> !match_capture_flag_a_r[1])
    else $error("transfer service left flag set");
  flag_hold_a: assert property (match_capture_flag_a_r[1]
    && !xfer[1].ack && !bus_req.wr |=> match_capture_flag_a_r[1])
    else $error("flag cleared without a write");
  ovf_hold_a: assert property ($fell(overflow_flag_r[0])
    |-> $past(bus_req.wr) || $past(hw_standby) || !$past(rst_n))
    else $error("overflow flag cleared without a write");
  halt_wr_a: assert property (bus_req.wr && bus_req.addr == 4'hF
    && bus_req.be == 2'h3 |=> timer_halt_bit_r == $past(bus_req.wdata[13]))
    else $error("halt bit does not follow its write");
  halt_rst_a: assert property ($rose(rst_n) && !bus_req.wr
    |=> timer_halt_bit_r) else $error("unit not halted after reset");
  pin_keep_a: assert property (timer_halt_bit_r && !io_ctrl_wr[2]
    |=> $stable(timer_io_pin_r[2])) else $error("pin moved while halted");

  cover property ($rose(overflow_flag_r[0]));
  cover property (xfer[1].ack && !xfer[1].disable_select_bit && !xfer[1].cnt_zero);
  cover property ($fell(timer_halt_bit_r));
endmodule : ptc_core_assertions

bind ptc_core ptc_core_assertions #(.NCH(NCH), .NGR(NGR)) chk (
  .clk, .rst_n, .hw_standby, .bus_req, .bus_rvalid_r, .gr_capture_mode,
  .capture_in, .xfer, .io_ctrl_wr, .match_capture_flag_a_r,
  .overflow_flag_r, .timer_io_pin_r, .timer_halt_bit_r
);

// [dv/ptc_xfer_model.sv]
// Transfer controller model that services match-A requests.
module ptc_xfer_model
  import ptc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Service strobes toward the timer
  output ptc_xfer_type [2:0] xfer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial xfer = '0;

  // Qualifiers are inverted on release so that stale levels never help.
  task automatic serve(input logic [1:0] ch, input logic dis, input logic cz);
    @(negedge clk) xfer[ch] = '{ack: 1'b1, disable_select_bit: dis, cnt_zero: cz};
    @(negedge clk) xfer[ch] = '{ack: 1'b0, disable_select_bit: ~dis, cnt_zero: ~cz};
  endtask : serve
endmodule : ptc_xfer_model

// [dv/tb_top.sv]
// Self-checking bench of the timer core.
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
  end

module tb_top
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, hw_standby, rvalid, halt;
  ptc_bus_req_type req;
  ptc_xfer_type [2:0] xfer;
  logic [15:0] rdata;
  logic [2:0] tick, phase, down, iowr, init, flag, ovf, pin;
  logic [2:0] clra, clrs, mlev;
  logic [7:0] capm, cap;
  logic [1:0] buf_en;
  int errors, cmp_count, n;

  ptc_core uut (.clk, .rst_n, .hw_standby, .bus_req(req),
    .bus_rdata_r(rdata), .bus_rvalid_r(rvalid), .count_tick(tick),
    .phase_mode(phase), .count_down(down), .clr_on_match_a(clra),
    .clr_by_sync(clrs), .gr_capture_mode(capm), .capture_in(cap),
    .buffer_en(buf_en), .xfer, .match_level(mlev), .io_ctrl_wr(iowr),
    .init_level(init), .match_capture_flag_a_r(flag), .overflow_flag_r(ovf),
    .timer_io_pin_r(pin), .timer_halt_bit_r(halt));
  ptc_xfer_model px (.clk, .xfer);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Bus and reporting tasks
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic to_chk(input bit hit);
    if (hit)
    begin
      errors++;
      summarize();
    end
  endtask : to_chk

  task automatic wr(input logic [3:0] a, input logic [1:0] b,
                    input logic [15:0] d);
    @(negedge clk) req = '{rd: 1'b0, wr: 1'b1, be: b, addr: a, wdata: d};
    @(negedge clk) req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    int k;
    @(negedge clk) req = '{rd: 1'b1, wr: 1'b0, be: 2'h3, addr: a, wdata: '0};
    @(negedge clk) req.rd = 1'b0;
    k = 0;
    while (rvalid !== 1'b1 && k < 4)
    begin
      @(negedge clk);
      k++;
    end
    to_chk(k == 4);
    d = rdata;
  endtask : rd

  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK("rdata", e, d)
  endtask : rc

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {rst_n, hw_standby, tick, phase, down, iowr, init} = '0;
    {capm, cap, buf_en, req, clra, clrs, mlev} = '0;
    {errors, cmp_count} = '0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int i = 0; i < 11; i++)
      rc(4'(i), (i < 3) ? 16'h0000 : 16'hFFFF);
    rc(4'hB, 16'h0000);
    rc(4'hF, 16'h3FFF);
    `CHK("halt", 1'b1, halt)
    $display("test reset done");
    wr(4'hA, 2'h1, 16'h1234);
    rc(4'hA, 16'hFFFF);
    wr(4'hA, 2'h3, 16'h1234);
    rc(4'hA, 16'h1234);
    wr(4'hB, 2'h3, 16'h0707);
    rc(4'hB, 16'h0707);
    wr(4'hB, 2'h2, 16'h0000);
    rc(4'hB, 16'h0007);
    wr(4'h0, 2'h3, 16'h1234);
    rc(4'h1, 16'h1234);
    rc(4'h2, 16'h1234);
    wr(4'hB, 2'h1, 16'h0000);
    wr(4'h0, 2'h3, 16'hFFF8);
    rc(4'h2, 16'h1234);
    $display("test access done");
    wr(4'h1, 2'h3, 16'h0040);
    {phase, down, tick} = {3'h7, 3'h7, 3'h7};
    mlev = 3'h1;
    wr(4'hF, 2'h3, 16'h0000);
    wr(4'hB, 2'h2, 16'h0300);
    n = 0;
    while (ovf[0] !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    to_chk(n == 40);
    wr(4'hB, 2'h2, 16'h0000);
    tick = '0;
    rc(4'h0, 16'h0002);
    rc(4'h1, 16'h0036);
    rc(4'h2, 16'h1234);
    `CHK("pin kept", 3'h1, pin)
    `CHK("flag a", 3'h1, flag)
    `CHK("overflow", 3'h1, ovf)
    wr(4'hC, 2'h1, 16'h0000);
    `CHK("flag kept", 1'b1, flag[0])
    rc(4'hC, 16'h0011);
    wr(4'hC, 2'h1, 16'h0000);
    `CHK("flags clear", 2'h0, {flag[0], ovf[0]})
    $display("test count done");
    capm = 8'h10;
    @(negedge clk) cap = 8'h10;
    @(negedge clk) cap = '0;
    `CHK("capture flag", 1'b1, flag[1])
    rc(4'h7, 16'h0036);
    px.serve(2'd1, 1'b1, 1'b0);
    px.serve(2'd1, 1'b0, 1'b1);
    `CHK("xfer kept", 1'b1, flag[1])
    px.serve(2'd1, 1'b0, 1'b0);
    `CHK("xfer clear", 1'b0, flag[1])
    capm = 8'h11;
    buf_en = 2'h1;
    wr(4'h3, 2'h3, 16'h1111);
    @(negedge clk) cap = 8'h01;
    @(negedge clk) cap = '0;
    rc(4'h3, 16'h0002);
    rc(4'h5, 16'h1111);
    {capm, buf_en, clra, clrs} = {8'h00, 2'h0, 3'h1, 3'h4};
    wr(4'h2, 2'h3, 16'h0050);
    wr(4'hB, 2'h3, 16'h0505);
    wr(4'hB, 2'h2, 16'h0000);
    rc(4'h0, 16'h0000);
    rc(4'h2, 16'h0000);
    rc(4'h1, 16'h0036);
    $display("test capture done");
    init = 3'h4;
    @(negedge clk) iowr = 3'h4;
    @(negedge clk) iowr = '0;
    `CHK("pin init", 3'h5, pin)
    @(negedge clk) hw_standby = 1'b1;
    @(negedge clk) hw_standby = 1'b0;
    rc(4'h0, 16'h0000);
    rc(4'h3, 16'hFFFF);
    rc(4'hF, 16'h3FFF);
    `CHK("flags", 6'h00, {flag, ovf})
    tick = 3'h1;
    wr(4'hB, 2'h2, 16'h0100);
    rc(4'h0, 16'h0000);
    $display("test standby done");
    summarize();
  end
endmodule : tb_top
